/* rtl/bsm_map.svh */
// bsm_map.svh: offsets, field positions, reset values and timing counts
// assumes: included by the slave module only; definitions only
`ifndef BSM_MAP_SVH
`define BSM_MAP_SVH

// -----------------------------------------------------------------
// register word indices, taken from address bits 3:1
// -----------------------------------------------------------------
`define BSM_IDX_STATUS   3'h0
`define BSM_IDX_CONTROL  3'h1
`define BSM_IDX_DATA     3'h2

// -----------------------------------------------------------------
// address decode
// -----------------------------------------------------------------
`define BSM_TOP_DIGIT    4'hf

// -----------------------------------------------------------------
// control and status fields
// -----------------------------------------------------------------
`define BSM_CTL_RUN      0
`define BSM_CTL_DIR      1
`define BSM_CTL_IE       2
`define BSM_STS_READY    0
`define BSM_STS_NOTRDY   1
`define BSM_STS_OVR      2
`define BSM_CTL_RESET    6'h00

// -----------------------------------------------------------------
// synchronised pin bits
// -----------------------------------------------------------------
`define BSM_SY_STB       0
`define BSM_SY_WR        1
`define BSM_SY_DONE      2
`define BSM_SY_CHAIN     3
`define BSM_SY_NRDY      4

// -----------------------------------------------------------------
// timing: data set-up before our strobe in the interrupt cycle
// -----------------------------------------------------------------
`define BSM_CLK_NS       20
`define BSM_STB_DLY_NS   60
`define BSM_STB_DLY_CYC  ((`BSM_STB_DLY_NS + `BSM_CLK_NS - 1) / `BSM_CLK_NS)

`endif

/* rtl/bsm_pkg.sv */
// bsm_pkg: types of the backplane slave module
// assumes: nothing beyond the standard language
package bsm_pkg;

  // -----------------------------------------------------------------
  // state machines
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_DONE} bsm_slv_t;
  typedef enum logic [2:0] {IR_IDLE, IR_REQ, IR_DELAY, IR_STROBE, IR_RELEASE} bsm_irq_t;

  // -----------------------------------------------------------------
  // whole module state, registered once per clock
  // -----------------------------------------------------------------
  typedef struct packed {
    bsm_slv_t    st;
    bsm_irq_t    ir;
    logic        rd;
    logic [5:0]  ctrl;
    logic [15:0] data;
    logic        rdy;
    logic        ovr;
    logic        outp;
    logic        served;
    logic [3:0]  cnt;
    logic [15:0] dout;
    logic [7:0]  strap;
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    logic [4:0]  f;
  } bsm_state_t;

endpackage

/* rtl/bsm_slave.sv */
// bsm_slave: slave interface of a plug-in module on the asynchronous backplane
// assumes: backplane lines other than the chain output are active low and open collector; the bench resolves
// each wire from the out/oe pairs; straps are static
`timescale 1ns/1ps
`include "bsm_map.svh"

module bsm_slave #(
  parameter int IRQ_LEVEL = 2
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // backplane address and cycle control
  input  wire logic [15:0] addr_n,
  input  wire logic        strobe_in_n,
  output logic             strobe_out_n,
  output logic             strobe_oe,
  input  wire logic        write_select_n,
  input  wire logic        done_in_n,
  output logic             done_out_n,
  output logic             done_oe,
  // backplane data
  input  wire logic [15:0] data_in_n,
  output logic      [15:0] data_out_n,
  output logic             data_oe,
  // interrupt request and priority chain
  output logic      [3:0]  service_request_line_out_n,
  output logic      [3:0]  service_request_line_oe,
  input  wire logic        priority_chain_signal_in_n,
  output logic             priority_chain_signal_out_n,
  // base address straps
  input  wire logic [7:0]  strap_base,
  // device side
  input  wire logic        dev_in_valid,
  input  wire logic [15:0] dev_in_data,
  output logic             dev_out_valid,
  input  wire logic        dev_out_ready,
  output logic      [15:0] dev_out_data,
  input  wire logic        dev_not_ready,
  output logic             dev_run,
  output logic      [2:0]  dev_cmd
);

  // levels one and four belong to system functions; refuse them when the module is built
  if (IRQ_LEVEL != 2 && IRQ_LEVEL != 3) begin : g_bad_level
    $error("bsm_slave: IRQ_LEVEL must be 2 or 3");
  end

  // the set-up counter is four bits wide and must count at least once
  if (`BSM_STB_DLY_CYC < 1 || `BSM_STB_DLY_CYC > 15) begin : g_bad_delay
    $error("bsm_slave: strobe delay does not fit the counter");
  end

  localparam logic [3:0] DLY_CYC  = 4'(`BSM_STB_DLY_CYC);
  localparam logic [3:0] IRQ_MASK = 4'(1 << (IRQ_LEVEL - 1));

  bsm_pkg::bsm_state_t q, d;

  logic [15:0] addr;
  logic [15:0] din;
  logic        match;
  logic [2:0]  idx;
  logic [15:0] devnum;
  logic        cause;
  logic [15:0] rdval;
  logic        out_load;

  // -----------------------------------------------------------------
  // address recognition
  // -----------------------------------------------------------------
  // pins are active low; invert once here so the logic reads active high
  assign addr   = ~addr_n;
  assign din    = ~data_in_n;
  assign match  = (addr[15:12] == `BSM_TOP_DIGIT) && (addr[11:4] == q.strap);
  assign idx    = addr[3:1];
  assign devnum = {`BSM_TOP_DIGIT, q.strap, 4'h0};
  assign cause  = q.rdy;

  // register read mux; holes in the block read zero
  always_comb begin
    rdval = 16'h0000;
    unique case (idx)
      `BSM_IDX_STATUS:  rdval = {12'h000, 1'b0, q.ovr, q.f[`BSM_SY_NRDY], q.rdy};
      `BSM_IDX_CONTROL: rdval = {10'h000, q.ctrl};
      `BSM_IDX_DATA:    rdval = q.data;
      default:          rdval = 16'h0000;
    endcase
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    d = q;
    out_load = 1'b0;
    // three-stage synchroniser, a change counts when stages two and three agree
    d.s1 = {dev_not_ready, ~priority_chain_signal_in_n, ~done_in_n, ~write_select_n, ~strobe_in_n};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f  = (q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3));
    d.strap = strap_base;

    // slave cycles; our own strobe during an interrupt cycle is not decoded
    unique case (q.st)
      bsm_pkg::ST_IDLE: begin
        if (q.f[`BSM_SY_STB] && match && (q.ir == bsm_pkg::IR_IDLE || q.ir == bsm_pkg::IR_REQ)) begin
          d.st = bsm_pkg::ST_DONE;
          d.rd = !q.f[`BSM_SY_WR];
          if (q.f[`BSM_SY_WR]) begin
            unique case (idx)
              `BSM_IDX_STATUS: begin
                // a status write clears the module rather than storing
                d.rdy  = 1'b0;
                d.ovr  = 1'b0;
                d.outp = 1'b0;
                d.ctrl = `BSM_CTL_RESET;
              end
              `BSM_IDX_CONTROL: d.ctrl = din[5:0];
              `BSM_IDX_DATA: begin
                d.data = din;
                if (q.ctrl[`BSM_CTL_DIR]) begin
                  d.outp   = 1'b1;
                  d.rdy    = 1'b0;
                  out_load = 1'b1;
                end
              end
              default: ;
            endcase
          end else begin
            d.dout = rdval;
            if (idx == `BSM_IDX_DATA && !q.ctrl[`BSM_CTL_DIR]) begin
              d.rdy = 1'b0;
            end
          end
        end
      end
      bsm_pkg::ST_DONE: begin
        // hold completion until the master drops its strobe
        if (!q.f[`BSM_SY_STB]) begin
          d.st = bsm_pkg::ST_IDLE;
          d.rd = 1'b0;
        end
      end
      default: d.st = bsm_pkg::ST_IDLE;
    endcase

    // device traffic; placed after the bus so a new word wins over a read clear
    if (dev_in_valid && q.ctrl[`BSM_CTL_RUN] && !q.ctrl[`BSM_CTL_DIR]) begin
      d.data = dev_in_data;
      d.rdy  = 1'b1;
      if (q.rdy) begin
        d.ovr = 1'b1;
      end
    end
    // a word loaded by the bus in the same cycle stays pending; the device took the older one
    if (dev_out_valid && dev_out_ready && !out_load) begin
      d.outp = 1'b0;
      d.rdy  = 1'b1;
    end

    // interrupt sequencer
    if (!cause) begin
      d.served = 1'b0;
    end
    unique case (q.ir)
      bsm_pkg::IR_IDLE: begin
        if (cause && !q.served && q.ctrl[`BSM_CTL_IE]) begin
          d.ir = bsm_pkg::IR_REQ;
        end
      end
      bsm_pkg::IR_REQ: begin
        if (!q.ctrl[`BSM_CTL_IE] || !cause) begin
          d.ir = bsm_pkg::IR_IDLE;
        end else if (q.f[`BSM_SY_CHAIN] && d.st == bsm_pkg::ST_IDLE) begin // never while a slave cycle owns the lines
          d.ir   = bsm_pkg::IR_DELAY;
          d.dout = {devnum[15:1], q.ctrl[`BSM_CTL_DIR]};
          d.cnt  = DLY_CYC;
        end
      end
      bsm_pkg::IR_DELAY: begin
        // data settles on the lines before the strobe goes out
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.ir = bsm_pkg::IR_STROBE;
        end
      end
      bsm_pkg::IR_STROBE: begin
        if (q.f[`BSM_SY_DONE]) begin
          d.ir     = bsm_pkg::IR_RELEASE;
          d.served = 1'b1;
        end
      end
      bsm_pkg::IR_RELEASE: begin
        if (!q.f[`BSM_SY_DONE] && !q.f[`BSM_SY_CHAIN]) begin
          d.ir = bsm_pkg::IR_IDLE;
        end
      end
      default: d.ir = bsm_pkg::IR_IDLE;
    endcase
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------
  // pin drive, backplane lines other than the chain output open collector and active low
  // -----------------------------------------------------------------
  assign done_oe      = (q.st == bsm_pkg::ST_DONE);
  assign done_out_n   = 1'b0;
  assign strobe_oe    = (q.ir == bsm_pkg::IR_STROBE);
  assign strobe_out_n = 1'b0;
  assign data_oe      = (q.st == bsm_pkg::ST_DONE && q.rd) ||
                        q.ir == bsm_pkg::IR_DELAY || q.ir == bsm_pkg::IR_STROBE;
  assign data_out_n   = ~q.dout;
  // service request on the chosen level only, dropped once the strobe is out
  assign service_request_line_oe    = (q.ir == bsm_pkg::IR_REQ || q.ir == bsm_pkg::IR_DELAY) ? IRQ_MASK : 4'h0;
  assign service_request_line_out_n = 4'h0;
  // the chain is a single gate from the raw pin; a synchroniser would cost the bus speed
  assign priority_chain_signal_out_n = priority_chain_signal_in_n | (q.ir != bsm_pkg::IR_IDLE);
  assign dev_out_valid = q.outp && q.ctrl[`BSM_CTL_RUN] && q.ctrl[`BSM_CTL_DIR];
  assign dev_out_data  = q.data;
  assign dev_run       = q.ctrl[`BSM_CTL_RUN];
  assign dev_cmd       = q.ctrl[5:3];

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  AST_DONE_FOLLOWS_STROBE: assert property (@(posedge mclk) disable iff (rst)
    (q.st == bsm_pkg::ST_IDLE && q.f[`BSM_SY_STB] && match && q.ir == bsm_pkg::IR_IDLE) |=> done_oe)
    else $error("completion not asserted after addressed strobe");
  AST_NO_FOREIGN_DONE: assert property (@(posedge mclk) disable iff (rst)
    (q.st == bsm_pkg::ST_IDLE && addr[15:12] != `BSM_TOP_DIGIT) |=> !done_oe)
    else $error("completion for foreign address");
  AST_READ_DRIVES: assert property (@(posedge mclk) disable iff (rst)
    (q.st == bsm_pkg::ST_IDLE && d.st == bsm_pkg::ST_DONE && !q.f[`BSM_SY_WR]) |=> (data_oe && q.dout == $past(rdval)))
    else $error("read data not driven");
  AST_WRITE_CTRL: assert property (@(posedge mclk) disable iff (rst)
    (q.st == bsm_pkg::ST_IDLE && d.st == bsm_pkg::ST_DONE && q.f[`BSM_SY_WR] && idx == `BSM_IDX_CONTROL)
    |=> q.ctrl == $past(din[5:0]))
    else $error("control write not captured");
  AST_STATUS_CLEARS: assert property (@(posedge mclk) disable iff (rst)
    (q.st == bsm_pkg::ST_IDLE && d.st == bsm_pkg::ST_DONE && q.f[`BSM_SY_WR] && idx == `BSM_IDX_STATUS
     && !dev_in_valid) |=> (!q.ovr && q.ctrl == `BSM_CTL_RESET))
    else $error("status write did not clear");
  AST_IE_GATES_SRL: assert property (@(posedge mclk) disable iff (rst)
    !q.ctrl[`BSM_CTL_IE] |=> service_request_line_oe == 4'h0 || q.ir == bsm_pkg::IR_DELAY)
    else $error("request forwarded with interrupts inhibited");
  AST_STROBE_DELAY: assert property (@(posedge mclk) disable iff (rst)
    (q.ir == bsm_pkg::IR_REQ && d.ir == bsm_pkg::IR_DELAY) |=> (data_oe && !strobe_oe)[*3] ##1 strobe_oe)
    else $error("strobe not delayed after device number");
  AST_DEVNUM: assert property (@(posedge mclk) disable iff (rst)
    strobe_oe |-> (q.dout == {devnum[15:1], q.ctrl[`BSM_CTL_DIR]}))
    else $error("wrong device number in interrupt cycle");
  AST_CHAIN_PASS: assert property (@(posedge mclk) disable iff (rst)
    q.ir == bsm_pkg::IR_IDLE |-> priority_chain_signal_out_n == priority_chain_signal_in_n)
    else $error("priority chain not passed");
  AST_CHAIN_BLOCKED: assert property (@(posedge mclk) disable iff (rst)
    q.ir != bsm_pkg::IR_IDLE |-> priority_chain_signal_out_n)
    else $error("priority chain passed while requesting");
  AST_SRL_LEVEL: assert property (@(posedge mclk) disable iff (rst)
    service_request_line_oe == 4'h0 || service_request_line_oe == IRQ_MASK)
    else $error("service request on the wrong level");
  AST_DONE_HOLDS: assert property (@(posedge mclk) disable iff (rst)
    (done_oe && q.f[`BSM_SY_STB]) |=> done_oe)
    else $error("completion dropped before the strobe");
  AST_WRITE_DATA: assert property (@(posedge mclk) disable iff (rst)
    (q.st == bsm_pkg::ST_IDLE && d.st == bsm_pkg::ST_DONE && q.f[`BSM_SY_WR] && idx == `BSM_IDX_DATA
     && !dev_in_valid) |=> q.data == $past(din))
    else $error("data write not captured");
  AST_HOLE_READS_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (q.st == bsm_pkg::ST_IDLE && d.st == bsm_pkg::ST_DONE && !q.f[`BSM_SY_WR] && idx > `BSM_IDX_DATA)
    |=> q.dout == 16'h0000)
    else $error("unimplemented register read not zero");
  AST_OVERRUN_SETS: assert property (@(posedge mclk) disable iff (rst)
    (dev_in_valid && q.ctrl[`BSM_CTL_RUN] && !q.ctrl[`BSM_CTL_DIR] && q.rdy) |=> q.ovr)
    else $error("second word did not flag overrun");
  AST_ONE_DATA_DRIVER: assert property (@(posedge mclk) disable iff (rst)
    !(q.st == bsm_pkg::ST_DONE && q.rd && (q.ir == bsm_pkg::IR_DELAY || q.ir == bsm_pkg::IR_STROBE)))
    else $error("read data and device number on the lines together");

endmodule

/* test/bsm_ctrl_model.sv */
// bsm_ctrl_model: bus controller seen from the slave, plus wire resolution
// assumes: open collector lines with pull-ups; bench acts as the bus master
`timescale 1ns/1ps

module bsm_ctrl_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // bench master drive
  input  wire logic        m_strobe_n,
  input  wire logic [15:0] m_data_n,
  input  wire logic        m_chain_n,
  input  wire logic [3:0]  grant_dly,
  // module drive
  input  wire logic        strobe_oe,
  input  wire logic        done_oe,
  input  wire logic        data_oe,
  input  wire logic [15:0] data_out_n,
  input  wire logic [3:0]  srl_oe,
  // resolved wires
  output logic             strobe_w,
  output logic             done_w,
  output logic [15:0]      data_w,
  output logic             chain_n,
  // last device number taken
  output logic [15:0]      irq_word,
  output logic [7:0]       irq_count
);
  logic [3:0] wait_q;
  logic       grant_q;
  logic       ack_q;

  // ---------------------------------------------------------------
  // wires: low wins, released lines float up to the pull-up level
  // ---------------------------------------------------------------
  assign strobe_w = m_strobe_n & ~strobe_oe;
  assign done_w   = ~done_oe & ~ack_q;
  assign data_w   = m_data_n & (data_oe ? data_out_n : 16'hffff);
  assign chain_n  = m_chain_n & ~grant_q;

  // grant grant_dly+1 cycles after the request is seen, so the bench can be prompt or slow
  always_ff @(posedge mclk) begin
    if (rst) begin
      wait_q    <= 4'h0;
      grant_q   <= 1'b0;
      ack_q     <= 1'b0;
      irq_word  <= 16'h0000;
      irq_count <= 8'h00;
    end else if (ack_q) begin
      // completion stands until the module lets go of the strobe
      if (strobe_w) begin
        ack_q   <= 1'b0;
        grant_q <= 1'b0;
        wait_q  <= 4'h0;
      end
    end else if (grant_q && !strobe_w) begin
      // device number is taken while the strobe is low
      irq_word  <= ~data_w;
      irq_count <= irq_count + 8'h01;
      ack_q     <= 1'b1;
    end else if ((|srl_oe) && !grant_q) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q == grant_dly) begin
        grant_q <= 1'b1;
      end
    end else if (!(|srl_oe) && !strobe_oe) begin
      // a withdrawn request loses its grant
      grant_q <= 1'b0;
      wait_q  <= 4'h0;
    end
  end
endmodule

/* test/bsm_slave_bench.sv */
// bsm_slave_bench: register cycles, device traffic and interrupt cycles
// assumes: bsm_ctrl_model resolves the shared lines; straps held static
`timescale 1ns/1ps

module bsm_slave_bench;
  localparam logic [7:0] STRAP = 8'h5a;
  logic        mclk = 1'b0, rst = 1'b1, m_strobe_n = 1'b1, write_select_n = 1'b1, m_chain_n = 1'b1;
  logic        dev_in_valid = 1'b0, dev_out_ready = 1'b0, dev_not_ready = 1'b0;
  logic [15:0] addr_n = 16'hffff, m_data_n = 16'hffff, dev_in_data = 16'h0000, data_out_n, data_w, irq_word;
  logic [15:0] dev_out_data, rd;
  logic [3:0]  grant_dly = 4'hf, srl_oe;
  logic [7:0]  irq_count;
  logic [3:0]  srl_out_n;
  logic        stb_out_n, done_out_n;
  logic [2:0]  dev_cmd;
  logic        strobe_oe, done_oe, data_oe, chain_out_n, dev_out_valid, dev_run, strobe_w, done_w, chain_n, ans;
  int          fail_count = 0, n_compared = 0;

  always #10 mclk = ~mclk;

  bsm_slave u_dut (.mclk(mclk), .rst(rst), .addr_n(addr_n), .strobe_in_n(strobe_w), .strobe_out_n(stb_out_n),
    .strobe_oe(strobe_oe), .write_select_n(write_select_n), .done_in_n(done_w), .done_out_n(done_out_n),
    .done_oe(done_oe), .data_in_n(data_w), .data_out_n(data_out_n), .data_oe(data_oe),
    .service_request_line_out_n(srl_out_n), .service_request_line_oe(srl_oe),
    .priority_chain_signal_in_n(chain_n), .priority_chain_signal_out_n(chain_out_n), .strap_base(STRAP),
    .dev_in_valid(dev_in_valid), .dev_in_data(dev_in_data), .dev_out_valid(dev_out_valid),
    .dev_out_ready(dev_out_ready), .dev_out_data(dev_out_data), .dev_not_ready(dev_not_ready), .dev_run(dev_run),
    .dev_cmd(dev_cmd));

  bsm_ctrl_model u_ctl (.mclk(mclk), .rst(rst), .m_strobe_n(m_strobe_n), .m_data_n(m_data_n),
    .m_chain_n(m_chain_n), .grant_dly(grant_dly), .strobe_oe(strobe_oe), .done_oe(done_oe), .data_oe(data_oe),
    .data_out_n(data_out_n), .srl_oe(srl_oe), .strobe_w(strobe_w), .done_w(done_w), .data_w(data_w),
    .chain_n(chain_n), .irq_word(irq_word), .irq_count(irq_count));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] adr(input int i);
    return {4'hf, STRAP, i[2:0], 1'b0};
  endfunction

  // ---------------------------------------------------------------
  // one backplane slave cycle; answer and data taken at the same edge
  // ---------------------------------------------------------------
  task automatic cyc(input logic wr, input logic [15:0] a, input logic [15:0] wd, output logic got_ans,
                     output logic [15:0] got);
    int n;
    @(posedge mclk);
    addr_n <= ~a;
    write_select_n <= ~wr;
    m_data_n <= wr ? ~wd : 16'hffff;
    m_strobe_n <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (done_w !== 1'b0 && n < 12);
    got_ans = (done_w === 1'b0);
    got = ~data_w;
    // everything is released together, only after the answering edge
    m_strobe_n <= 1'b1;
    addr_n <= 16'hffff;
    write_select_n <= 1'b1;
    m_data_n <= 16'hffff;
    // the strobe stays high long enough for the module's filter to see it negated
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((done_w !== 1'b1 || n < 5) && n < 12);
    if (done_w !== 1'b1) begin
      chk("done release", 16'h0001, 16'h0000);
      end_of_test();
    end
  endtask

  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    cyc(1'b1, a, d, ans, rd);
    chk("write done", 16'h0001, {15'h0000, ans});
    if (ans !== 1'b1) end_of_test();
  endtask

  task automatic rdchk(input string what, input logic [15:0] a, input logic [15:0] exp);
    cyc(1'b0, a, 16'h0000, ans, rd);
    chk("read done", 16'h0001, {15'h0000, ans});
    if (ans !== 1'b1) end_of_test();
    chk(what, exp, rd);
  endtask

  task automatic pulse(input logic [15:0] d);
    @(posedge mclk);
    dev_in_valid <= 1'b1;
    dev_in_data <= d;
    @(posedge mclk);
    dev_in_valid <= 1'b0;
  endtask

  task automatic wait_irq(input logic [7:0] c);
    for (int k = 0; k < 80 && irq_count !== c; k++) @(posedge mclk);
    chk("interrupt cycles", {8'h00, c}, {8'h00, irq_count});
    if (irq_count !== c) end_of_test();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("drive levels", 16'h0000, {10'h000, srl_out_n, stb_out_n, done_out_n});
    rdchk("status reset", adr(0), 16'h0000);
    rdchk("control reset", adr(1), 16'h0000);
    wr16(adr(1), 16'hff39);
    chk("run", 16'h0001, {15'h0000, dev_run});
    chk("command", 16'h0007, {13'h0000, dev_cmd});
    rdchk("control", adr(1), 16'h0039);
    wr16(adr(2) | 16'h0001, 16'ha5c3);
    rdchk("data", adr(2), 16'ha5c3);
    for (int i = 3; i < 8; i++) begin
      wr16(adr(i), 16'hffff);
      rdchk("hole", adr(i), 16'h0000);
    end
    cyc(1'b0, {4'he, STRAP, 4'h0}, 16'h0000, ans, rd);
    chk("top digit", 16'h0000, {15'h0000, ans});
    cyc(1'b0, {4'hf, STRAP ^ 8'h01, 4'h0}, 16'h0000, ans, rd);
    chk("strap", 16'h0000, {15'h0000, ans});
    // two words in input mode with interrupts off: overrun, no request
    dev_not_ready <= 1'b1;
    pulse(16'h1234);
    pulse(16'h5678);
    repeat (6) @(posedge mclk);
    chk("masked request", 16'h0000, {12'h000, srl_oe});
    rdchk("status", adr(0), 16'h0007);
    rdchk("overrun data", adr(2), 16'h5678);
    wr16(adr(0), 16'h0000);
    rdchk("cleared status", adr(0), 16'h0002);
    rdchk("cleared control", adr(1), 16'h0000);
    m_chain_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("chain pass", 16'h0000, {15'h0000, chain_out_n});
    m_chain_n <= 1'b1;
    dev_not_ready <= 1'b0;
    // input interrupt, slow grant
    wr16(adr(1), 16'h0005);
    pulse(16'h00c7);
    for (int k = 0; k < 10 && srl_oe === 4'h0; k++) @(posedge mclk);
    chk("request level", 16'h0002, {12'h000, srl_oe});
    if (srl_oe === 4'h0) end_of_test();
    wait_irq(8'h01);
    chk("device number in", {4'hf, STRAP, 4'h0}, irq_word);
    repeat (8) @(posedge mclk);
    rdchk("input data", adr(2), 16'h00c7);
    // output interrupt, prompt grant
    grant_dly <= 4'h0;
    wr16(adr(1), 16'h0007);
    wr16(adr(2), 16'hbeef);
    chk("out valid", 16'h0001, {15'h0000, dev_out_valid});
    chk("out data", 16'hbeef, dev_out_data);
    @(posedge mclk);
    dev_out_ready <= 1'b1;
    @(posedge mclk);
    dev_out_ready <= 1'b0;
    wait_irq(8'h02);
    chk("out taken", 16'h0000, {15'h0000, dev_out_valid});
    chk("device number out", {4'hf, STRAP, 4'h1}, irq_word);
    repeat (8) @(posedge mclk);
    // reset in mid-run: every line released, control back to stop
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("reset drive", 16'h0000, {9'h000, srl_oe, strobe_oe, done_oe, data_oe});
    chk("reset run", 16'h0000, {15'h0000, dev_run});
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    rdchk("control after reset", adr(1), 16'h0000);
    end_of_test();
  end
endmodule
